// *** design/cmr_pkg.sv ***
package cmr_pkg;
  localparam logic [7:0] CMR_MODE_ADDR = 8'h9D;
  localparam logic [7:0] CMR_MUX_ADDR = 8'h9F;
  localparam logic [7:0] CMR_MUX_RESET = 8'hFF;
  localparam logic [7:0] CMR_MODE_RESET = 8'h02;
  localparam int CMR_RISE_EN_POS = 5;
  localparam int CMR_FALL_EN_POS = 4;
  localparam logic [7:0] CMR_MODE_WMASK = 8'h33;
  localparam int CMR_NEG_SEL_POS = 4;
  localparam int CMR_POS_SEL_POS = 0;
  localparam int CMR_SEL_OFF_POS = 3;
  localparam int CMR_NUM_PINS = 8;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cmr_sfr_req_t;

  typedef struct packed {
    logic valid;
    logic [7:0] pin_sel;
  } cmr_route_t;
endpackage : cmr_pkg

// *** design/cmr_route_dec.sv ***
`timescale 1ns/1ps
module cmr_route_dec
  import cmr_pkg::*;
(
  // Select nibble
  input wire logic [3:0] sel,
  // One-hot route
  output cmr_route_t route
);
  always_comb begin
    route.valid = ~sel[CMR_SEL_OFF_POS];
    route.pin_sel = 8'h00;
    if (!sel[CMR_SEL_OFF_POS]) begin
      route.pin_sel[sel[2:0]] = 1'b1;
    end
  end
endmodule : cmr_route_dec

// *** design/cmr_regs.sv ***
`timescale 1ns/1ps
// Behaviour
// - Negative select top bit zero: low bits pick P0.1,P0.3..P1.7 odd pins.
// - Negative select top bit one: no pin on negative input.
// - Positive select top bit zero: low bits pick P0.0,P0.2..P1.6 even pins.
// - Positive select top bit one: no pin on positive input.
// - Input select resets to all ones; all eight bits read/write.
// - Mode bit 5 enables rising-edge interrupt.
// - Mode bit 4 enables falling-edge interrupt.
// - Mode bits 7-6 and 3-2 read zero, writes discarded.
// - Mode bits 1-0 give response mode, driven continuously to comparator.
// - Mode register resets to 0x02.
// - Rising output edge sets rise flag; falling edge sets fall flag.
// - Edge flags stay set until FLAG_CLR_RISE or FLAG_CLR_FALL clears them.
module cmr_regs
  import cmr_pkg::*;
(
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RST_B,
  // Special-function-register access
  input wire cmr_sfr_req_t SFR_REQ,
  output logic [7:0] SFR_RDATA,
  output logic SFR_HIT,
  // Comparator side
  input wire logic CMP_OUT,
  input wire logic FLAG_CLR_RISE,
  input wire logic FLAG_CLR_FALL,
  output logic RISE_EDGE_FLAG,
  output logic FALL_EDGE_FLAG,
  output logic [1:0] RESPONSE_MODE,
  output logic [7:0] NEG_PIN_SEL,
  output logic NEG_PIN_VALID,
  output logic [7:0] POS_PIN_SEL,
  output logic POS_PIN_VALID,
  output logic CMP_IRQ
);
  logic [7:0] comparator_input_select_q;
  logic [7:0] comparator_mode_select_q;
  logic cmp_prev_q;
  logic rise_edge_flag_q;
  logic fall_edge_flag_q;
  logic [7:0] rdata_d;
  logic hit_d;
  cmr_route_t neg_route;
  cmr_route_t pos_route;

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      comparator_input_select_q <= CMR_MUX_RESET;
    end else if (SFR_REQ.wr && SFR_REQ.addr == CMR_MUX_ADDR) begin
      comparator_input_select_q <= SFR_REQ.wdata;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      comparator_mode_select_q <= CMR_MODE_RESET;
    end else if (SFR_REQ.wr && SFR_REQ.addr == CMR_MODE_ADDR) begin
      comparator_mode_select_q <= SFR_REQ.wdata & CMR_MODE_WMASK;
    end
  end

  // Comparator output is taken as already synchronous to the core clock
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      cmp_prev_q <= 1'b0;
    end else begin
      cmp_prev_q <= CMP_OUT;
    end
  end

  // Set beats clear so an edge in the clearing cycle is not lost
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      rise_edge_flag_q <= 1'b0;
      fall_edge_flag_q <= 1'b0;
    end else begin
      if (CMP_OUT && !cmp_prev_q) begin
        rise_edge_flag_q <= 1'b1;
      end else if (FLAG_CLR_RISE) begin
        rise_edge_flag_q <= 1'b0;
      end
      if (!CMP_OUT && cmp_prev_q) begin
        fall_edge_flag_q <= 1'b1;
      end else if (FLAG_CLR_FALL) begin
        fall_edge_flag_q <= 1'b0;
      end
    end
  end

  always_comb begin
    rdata_d = 8'h00;
    hit_d = 1'b0;
    if (SFR_REQ.addr == CMR_MUX_ADDR) begin
      rdata_d = comparator_input_select_q;
      hit_d = 1'b1;
    end else if (SFR_REQ.addr == CMR_MODE_ADDR) begin
      rdata_d = comparator_mode_select_q & CMR_MODE_WMASK;
      hit_d = 1'b1;
    end
  end

  // Read data registered: valid the edge after the read strobe
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      SFR_RDATA <= 8'h00;
      SFR_HIT <= 1'b0;
    end else begin
      SFR_RDATA <= SFR_REQ.rd ? rdata_d : 8'h00;
      SFR_HIT <= SFR_REQ.rd & hit_d;
    end
  end

  cmr_route_dec u_neg_dec (
    .sel(comparator_input_select_q[CMR_NEG_SEL_POS +: 4]),
    .route(neg_route)
  );

  cmr_route_dec u_pos_dec (
    .sel(comparator_input_select_q[CMR_POS_SEL_POS +: 4]),
    .route(pos_route)
  );

  // Bit n of a select vector is the nth pin of its odd or even list
  assign NEG_PIN_SEL = neg_route.pin_sel;
  assign NEG_PIN_VALID = neg_route.valid;
  assign POS_PIN_SEL = pos_route.pin_sel;
  assign POS_PIN_VALID = pos_route.valid;

  assign RESPONSE_MODE = comparator_mode_select_q[1:0];
  assign RISE_EDGE_FLAG = rise_edge_flag_q;
  assign FALL_EDGE_FLAG = fall_edge_flag_q;
  assign CMP_IRQ = (rise_edge_flag_q & comparator_mode_select_q[CMR_RISE_EN_POS])
                 | (fall_edge_flag_q & comparator_mode_select_q[CMR_FALL_EN_POS]);
endmodule : cmr_regs

// *** dv/cmr_regs_assertions.sv ***
`timescale 1ns/1ps
module cmr_regs_chk
  import cmr_pkg::*;
(
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RST_B,
  // Register access
  input wire cmr_sfr_req_t SFR_REQ,
  input wire logic [7:0] SFR_RDATA,
  input wire logic SFR_HIT,
  // Comparator side
  input wire logic CMP_OUT,
  input wire logic FLAG_CLR_RISE,
  input wire logic RISE_EDGE_FLAG,
  input wire logic FALL_EDGE_FLAG,
  input wire logic [1:0] RESPONSE_MODE,
  input wire logic [7:0] NEG_PIN_SEL,
  input wire logic [7:0] POS_PIN_SEL,
  input wire logic CMP_IRQ
);
  logic mx, md;
  logic [7:0] d;
  assign d = SFR_REQ.wdata;
  assign mx = SFR_REQ.wr && SFR_REQ.addr == CMR_MUX_ADDR;
  assign md = SFR_REQ.wr && SFR_REQ.addr == CMR_MODE_ADDR;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B);
  chk_neg_route: assert property (mx |=> NEG_PIN_SEL ==
    ($past(d[7]) ? 8'h00 : 8'h01 << $past(d[6:4]))) else $error("neg route wrong");
  chk_pos_route: assert property (mx |=> POS_PIN_SEL ==
    ($past(d[3]) ? 8'h00 : 8'h01 << $past(d[2:0]))) else $error("pos route wrong");
  chk_mode_out: assert property (md |=> RESPONSE_MODE == $past(d[1:0]))
    else $error("response mode wrong");
  chk_mode_read: assert property (SFR_REQ.rd && SFR_REQ.addr == CMR_MODE_ADDR |=>
    SFR_HIT && (SFR_RDATA & 8'hCC) == 8'h00) else $error("mode read wrong");
  chk_rise_set: assert property ($rose(CMP_OUT) |=> RISE_EDGE_FLAG)
    else $error("rise flag not set");
  chk_fall_set: assert property ($fell(CMP_OUT) |=> FALL_EDGE_FLAG)
    else $error("fall flag not set");
  chk_flag_hold: assert property (RISE_EDGE_FLAG && !FLAG_CLR_RISE |=> RISE_EDGE_FLAG)
    else $error("rise flag lost");
  chk_irq_idle: assert property (!RISE_EDGE_FLAG && !FALL_EDGE_FLAG |-> !CMP_IRQ)
    else $error("irq without flag");
  chk_bad_read: assert property (SFR_REQ.rd && SFR_REQ.addr == 8'h9E |=>
    !SFR_HIT && SFR_RDATA == 8'h00) else $error("unmapped read answered");
  cover property (CMP_IRQ);
  cover property (mx);
  cover property (SFR_HIT);
endmodule : cmr_regs_chk
bind cmr_regs cmr_regs_chk u_chk (.*);

// *** dv/tb_top.sv ***
`timescale 1ns/1ps
module tb_top
  import cmr_pkg::*;
;
  // Port names kept so the instance can connect by name
  logic CORE_CLK = 0, RST_B = 0, CMP_OUT = 0, FLAG_CLR_RISE = 0, FLAG_CLR_FALL = 0;
  cmr_sfr_req_t SFR_REQ = '0;
  logic [7:0] SFR_RDATA, NEG_PIN_SEL, POS_PIN_SEL;
  logic SFR_HIT, RISE_EDGE_FLAG, FALL_EDGE_FLAG, NEG_PIN_VALID, POS_PIN_VALID, CMP_IRQ;
  logic [1:0] RESPONSE_MODE;
  int miscompares = 0, check_count = 0;
  cmr_regs uut (.*);
  initial forever #12.5 CORE_CLK = ~CORE_CLK;
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask : chk
  // One-cycle strobe, then look just after the taking edge
  task automatic acc(logic w, logic [7:0] a, logic [7:0] v);
    @(posedge CORE_CLK) SFR_REQ <= {w, !w, a, v};
    @(posedge CORE_CLK) SFR_REQ <= '0;
    #1;
  endtask : acc
  // Only the two mapped offsets answer a read
  task automatic rd(logic [7:0] a, logic [7:0] e);
    acc(0, a, 8'h00);
    chk("read", e, SFR_RDATA);
    chk("hit", {7'h00, (a == CMR_MUX_ADDR) || (a == CMR_MODE_ADDR)}, SFR_HIT);
  endtask : rd
  task automatic cmp(logic v);
    @(posedge CORE_CLK) CMP_OUT <= v;
    @(posedge CORE_CLK) #1;
  endtask : cmp
  task report_and_stop;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (2000) @(posedge CORE_CLK);
    miscompares++;
    report_and_stop;
  end
  initial begin
    repeat (5) @(posedge CORE_CLK);
    RST_B <= 1;
    rd(CMR_MUX_ADDR, 8'hFF);
    rd(CMR_MODE_ADDR, 8'h02);
    $display("reset test done");
    for (int k = 0; k < 8; k++) begin
      acc(1, CMR_MUX_ADDR, 8'(k * 17));
      chk("neg", 8'h01 << k, NEG_PIN_SEL);
      chk("pos", 8'h01 << k, POS_PIN_SEL);
      chk("valid", 8'h03, {NEG_PIN_VALID, POS_PIN_VALID});
    end
    acc(1, CMR_MUX_ADDR, 8'h85);
    chk("neg", 8'h00, {NEG_PIN_VALID, NEG_PIN_SEL[6:0]});
    acc(1, CMR_MUX_ADDR, 8'h38);
    chk("pos", 8'h00, {POS_PIN_VALID, POS_PIN_SEL[6:0]});
    rd(CMR_MUX_ADDR, 8'h38);
    rd(8'h9E, 8'h00);
    $display("route test done");
    for (int m = 0; m < 4; m++) begin
      acc(1, CMR_MODE_ADDR, 8'hCC | 8'(m));
      chk("mode", 8'(m), RESPONSE_MODE);
      rd(CMR_MODE_ADDR, 8'(m));
    end
    $display("mode test done");
    acc(1, CMR_MODE_ADDR, 8'h20);
    cmp(1);
    chk("irq", 8'h01, CMP_IRQ);
    acc(1, CMR_MODE_ADDR, 8'h10);
    chk("irq", 8'h02, {RISE_EDGE_FLAG, CMP_IRQ});
    cmp(0);
    chk("irq", 8'h03, {FALL_EDGE_FLAG, CMP_IRQ});
    @(posedge CORE_CLK) {FLAG_CLR_RISE, FLAG_CLR_FALL} <= 2'b11;
    @(posedge CORE_CLK) {FLAG_CLR_RISE, FLAG_CLR_FALL} <= 2'b00;
    #1 chk("irq", 8'h00, CMP_IRQ);
    chk("flags", 8'h00, {RISE_EDGE_FLAG, FALL_EDGE_FLAG});
    // Edge and clear in one cycle: the edge must survive
    @(posedge CORE_CLK) begin
      CMP_OUT <= 1'b1;
      FLAG_CLR_RISE <= 1'b1;
    end
    @(posedge CORE_CLK) FLAG_CLR_RISE <= 1'b0;
    #1 chk("setwin", 8'h01, RISE_EDGE_FLAG);
    $display("edge test done");
    report_and_stop;
  end
endmodule : tb_top
